// [logic/dcp_pkg.sv]
// Purpose: Constants and types for the digitizer context packet builder
// Assumes: 32-bit packet words, one clock
// Notes:   Field positions refer to the header and indicator words

package dcp_pkg;

  // ****************************************
  // Header fields
  // ****************************************
  localparam logic [3:0]  PKT_TYPE_CTX   = 4'h4;
  localparam logic [1:0]  INT_KIND_UTC   = 2'h1;
  localparam logic [1:0]  FRAC_KIND_PS   = 2'h2;
  localparam logic        CLASS_PRESENT  = 1'b0;
  localparam logic [1:0]  HDR_RSV_VAL    = 2'h0;
  localparam logic        TS_PRECISE     = 1'b0;
  localparam int          HDR_TYPE_LSB   = 28;
  localparam int          HDR_CLASS_BIT  = 27;
  localparam int          HDR_RSV_LSB    = 25;
  localparam int          HDR_PREC_BIT   = 24;
  localparam int          HDR_IKND_LSB   = 22;
  localparam int          HDR_FKND_LSB   = 20;
  localparam int          HDR_CNT_LSB    = 16;
  localparam logic [3:0]  SEQ_RESET      = 4'h0;

  // ****************************************
  // Fixed words and sizes
  // ****************************************
  localparam logic [31:0] STREAM_ID      = 32'h0900_0002;
  localparam logic [15:0] FIXED_WORDS    = 16'h0006;
  localparam logic [15:0] BW_WORDS       = 16'h0002;
  localparam logic [15:0] FO_WORDS       = 16'h0002;
  localparam logic [15:0] RL_WORDS       = 16'h0001;

  // ****************************************
  // Indicator word bits
  // ****************************************
  localparam int          IND_CHG_BIT    = 31;
  localparam int          IND_BW_BIT     = 29;
  localparam int          IND_FO_BIT     = 26;
  localparam int          IND_RL_BIT     = 24;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HDR, ST_SID, ST_SEC, ST_PS_HI, ST_PS_LO, ST_IND,
    ST_BW_HI, ST_BW_LO, ST_FO_HI, ST_FO_LO, ST_RL
  } dcp_state_t;

endpackage

// [logic/dcp_buf.sv]
// Purpose: Two-entry buffer between packet builder and receiver
// Assumes: Source and sink on clk_i
// Notes:   Data and valid outputs are flip-flops, ready is the inverted skid flag; a sink stall loses no word

`timescale 1ns/1ps

module dcp_buf #(
  parameter int WIDTH = 33
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  // Drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  logic [WIDTH-1:0] skid_r;
  logic             skid_v_r;

  if (WIDTH < 1)
  begin : g_chk
    $error("dcp_buf needs WIDTH of at least 1");
  end

  // Ready is just the empty skid slot, so it never waits on the sink
  assign in_ready_o = ~skid_v_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_data_o  <= '0;
      out_valid_o <= 1'b0;
      skid_r      <= '0;
      skid_v_r    <= 1'b0;
    end
    else if (out_ready_i || !out_valid_o)
    begin
      if (skid_v_r)
      begin
        out_data_o  <= skid_r;
        out_valid_o <= 1'b1;
        skid_v_r    <= 1'b0;
      end
      else
      begin
        out_data_o  <= in_data_i;
        out_valid_o <= in_valid_i;
      end
    end
    else if (in_valid_i && !skid_v_r)
    begin
      skid_r   <= in_data_i;
      skid_v_r <= 1'b1;
    end
  end

  no_loss_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o)))
    else $error("buffer output changed while stalled");

endmodule

// [logic/dcp_builder.sv]
// Purpose: Builds digitizer context packets on change of bandwidth, offset or level
// Assumes: Value inputs come from logic on clk_i; packets drain over valid/ready
// Notes:   A no-change report carries all three fields with the change flag clear
//
// How it works
// - Header packet type is the context packet code 0100.
// - Class identifier bit is clear and no class word is sent.
// - Two reserved header bits are zero.
// - Timestamp precision flag is zero, timestamps are precise.
// - Integer time kind is 01, seconds are UTC.
// - Fraction time kind is 10, real-time picoseconds.
// - Four-bit packet counter starts at zero, adds one per packet, wraps.
// - Length field counts every word of the packet.
// - Stream identifier word 0x9000002 follows the header.
// - Seconds word carries UTC seconds since 1970.
// - Two picosecond words carry picoseconds since the last second.
// - Indicator bits 29, 26, 24 flag bandwidth, offset, level fields.
// - One field appended per set presence bit, none for clear bits.
// - Fields follow indicator bit order, most significant first.
// - Bit 31 set on change with changed bits; clear means no change.
// - Bandwidth reports the span viewable under current decimation.
// - Bandwidth is 64-bit two's complement hertz, 20 fraction bits.
// - Frequency offset is 64-bit two's complement hertz, 20 fraction bits.
// - Reference level word has upper 16 bits zero, signed Q9.7 dBm.
// - Length field is in 32-bit words.

`timescale 1ns/1ps

module dcp_builder
  import dcp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Context values
  input  wire logic [63:0] span_bw_i,
  input  wire logic [63:0] freq_offset_i,
  input  wire logic [15:0] ref_level_i,
  // Time of day
  input  wire logic [31:0] utc_sec_i,
  input  wire logic [63:0] utc_ps_i,
  // Request for a no-change report
  input  wire logic        report_i,
  // Packet stream
  output logic [31:0]      word_o,
  output logic             valid_o,
  output logic             last_o,
  input  wire logic        ready_i,
  // Status
  output logic             busy_o,
  output logic [3:0]       seq_count_o
);

  // ****************************************
  // State
  // ****************************************
  dcp_state_t  st_r;
  logic [63:0] rep_bw_r;
  logic [63:0] rep_fo_r;
  logic [15:0] rep_rl_r;
  logic [63:0] bw_r;
  logic [63:0] fo_r;
  logic [15:0] rl_r;
  logic [31:0] sec_r;
  logic [63:0] ps_r;
  logic [31:0] ind_r;
  logic [15:0] len_r;
  logic [3:0]  seq_r;
  logic        rep_req_r;
  logic        chg_bw;
  logic        chg_fo;
  logic        chg_rl;
  logic        any_chg;
  logic        start;
  logic [31:0] ind_nxt;
  logic [31:0] word;
  logic        in_ready;
  logic        push;
  logic        last;
  dcp_state_t  st_nxt;

  // Next field after a given step, by indicator order; ST_IDLE ends the packet
  function automatic dcp_state_t next_step(dcp_state_t s, logic [31:0] ind);
    dcp_state_t n;
    n = ST_IDLE;
    unique case (s)
      ST_HDR:   n = ST_SID;
      ST_SID:   n = ST_SEC;
      ST_SEC:   n = ST_PS_HI;
      ST_PS_HI: n = ST_PS_LO;
      ST_PS_LO: n = ST_IND;
      ST_IND:   n = ind[IND_BW_BIT] ? ST_BW_HI :
                    ind[IND_FO_BIT] ? ST_FO_HI :
                    ind[IND_RL_BIT] ? ST_RL : ST_IDLE;
      ST_BW_HI: n = ST_BW_LO;
      ST_BW_LO: n = ind[IND_FO_BIT] ? ST_FO_HI :
                    ind[IND_RL_BIT] ? ST_RL : ST_IDLE;
      ST_FO_HI: n = ST_FO_LO;
      ST_FO_LO: n = ind[IND_RL_BIT] ? ST_RL : ST_IDLE;
      ST_RL:    n = ST_IDLE;
      ST_IDLE:  n = ST_IDLE;
    endcase
    return n;
  endfunction

  // ****************************************
  // Change detection
  // ****************************************
  assign chg_bw  = (span_bw_i != rep_bw_r);
  assign chg_fo  = (freq_offset_i != rep_fo_r);
  assign chg_rl  = (ref_level_i != rep_rl_r);
  assign any_chg = chg_bw | chg_fo | chg_rl;
  assign start   = (st_r == ST_IDLE) && (any_chg || rep_req_r);

  always_comb
  begin
    ind_nxt = '0;
    if (any_chg)
    begin
      ind_nxt[IND_CHG_BIT] = 1'b1;
      ind_nxt[IND_BW_BIT]  = chg_bw;
      ind_nxt[IND_FO_BIT]  = chg_fo;
      ind_nxt[IND_RL_BIT]  = chg_rl;
    end
    else
    begin
      // No change: full snapshot, change flag clear
      ind_nxt[IND_BW_BIT] = 1'b1;
      ind_nxt[IND_FO_BIT] = 1'b1;
      ind_nxt[IND_RL_BIT] = 1'b1;
    end
  end

  // Request kept until a packet starts; a new request in that cycle wins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rep_req_r <= 1'b0;
    else if (report_i)
      rep_req_r <= 1'b1;
    else if (start)
      rep_req_r <= 1'b0;
  end

  // ****************************************
  // Snapshot taken at packet start
  // ****************************************
  // Values are frozen so a change mid-packet waits for the next one
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rep_bw_r <= '0;
      rep_fo_r <= '0;
      rep_rl_r <= '0;
      bw_r     <= '0;
      fo_r     <= '0;
      rl_r     <= '0;
      sec_r    <= '0;
      ps_r     <= '0;
      ind_r    <= '0;
      len_r    <= '0;
    end
    else if (start)
    begin
      rep_bw_r <= span_bw_i;
      rep_fo_r <= freq_offset_i;
      rep_rl_r <= ref_level_i;
      bw_r     <= span_bw_i;
      fo_r     <= freq_offset_i;
      rl_r     <= ref_level_i;
      sec_r    <= utc_sec_i;
      ps_r     <= utc_ps_i;
      ind_r    <= ind_nxt;
      len_r    <= FIXED_WORDS
                + (ind_nxt[IND_BW_BIT] ? BW_WORDS : 16'h0000)
                + (ind_nxt[IND_FO_BIT] ? FO_WORDS : 16'h0000)
                + (ind_nxt[IND_RL_BIT] ? RL_WORDS : 16'h0000);
    end
  end

  // ****************************************
  // Word sequencing
  // ****************************************
  assign push   = (st_r != ST_IDLE) && in_ready;
  assign st_nxt = next_step(st_r, ind_r);
  assign last   = (st_nxt == ST_IDLE);

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st_r <= ST_IDLE;
    else if (start)
      st_r <= ST_HDR;
    else if (push)
      st_r <= st_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      seq_r <= SEQ_RESET;
    else if (push && st_r == ST_HDR)
      seq_r <= seq_r + 4'h1;
  end

  always_comb
  begin
    word = '0;
    unique case (st_r)
      ST_HDR:
      begin
        word[HDR_TYPE_LSB +: 4] = PKT_TYPE_CTX;
        word[HDR_CLASS_BIT]     = CLASS_PRESENT;
        word[HDR_RSV_LSB +: 2]  = HDR_RSV_VAL;
        word[HDR_PREC_BIT]      = TS_PRECISE;
        word[HDR_IKND_LSB +: 2] = INT_KIND_UTC;
        word[HDR_FKND_LSB +: 2] = FRAC_KIND_PS;
        word[HDR_CNT_LSB +: 4]  = seq_r;
        word[15:0]              = len_r;
      end
      ST_SID:   word = STREAM_ID;
      ST_SEC:   word = sec_r;
      ST_PS_HI: word = ps_r[63:32];
      ST_PS_LO: word = ps_r[31:0];
      ST_IND:   word = ind_r;
      ST_BW_HI: word = bw_r[63:32];
      ST_BW_LO: word = bw_r[31:0];
      ST_FO_HI: word = fo_r[63:32];
      ST_FO_LO: word = fo_r[31:0];
      ST_RL:    word = {16'h0000, rl_r};
      ST_IDLE:  word = '0;
    endcase
  end

  // ****************************************
  // Output buffer and status
  // ****************************************
  dcp_buf #(
    .WIDTH (33)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({last, word}),
    .in_valid_i  (st_r != ST_IDLE),
    .in_ready_o  (in_ready),
    .out_data_o  ({last_o, word_o}),
    .out_valid_o (valid_o),
    .out_ready_i (ready_i)
  );

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o      <= 1'b0;
      seq_count_o <= SEQ_RESET;
    end
    else
    begin
      busy_o      <= (st_r != ST_IDLE) || start;
      seq_count_o <= seq_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] wcnt_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      wcnt_r <= '0;
    else if (push)
      wcnt_r <= last ? 16'h0000 : wcnt_r + 16'h0001;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence hdr_push_s;
    push && st_r == ST_HDR;
  endsequence

  sequence id_push_s;
    push && st_r == ST_SID;
  endsequence

  hdr_type_a: assert property (hdr_push_s |-> word[31:28] == 4'h4)
    else $error("header type not context");
  hdr_class_a: assert property (hdr_push_s |-> !word[27] ##1 st_r == ST_SID)
    else $error("class bit set or class word sent");
  hdr_rsv_a: assert property (hdr_push_s |-> word[26:25] == 2'h0)
    else $error("reserved header bits nonzero");
  hdr_kinds_a: assert property (hdr_push_s |-> word[24:20] == 5'h06)
    else $error("timestamp mode or kinds wrong");
  seq_step_a: assert property (hdr_push_s |=> seq_r == $past(seq_r) + 4'h1)
    else $error("packet counter did not step by one");
  pkt_len_a: assert property ((push && last) |-> wcnt_r + 16'h0001 == len_r)
    else $error("word count differs from length field");
  stream_id_a: assert property (id_push_s |-> word == 32'h0900_0002)
    else $error("stream identifier wrong");
  chg_flag_a: assert property ((push && st_r == ST_IND && word[31])
    |-> (word[29] || word[26] || word[24]))
    else $error("change flag with no changed field");
  rl_upper_a: assert property ((push && st_r == ST_RL) |-> word[31:16] == 16'h0000)
    else $error("reference level upper half nonzero");
  chg_start_a: assert property ((st_r == ST_IDLE && any_chg) |=> st_r == ST_HDR)
    else $error("change did not start a packet");

  // ****************************************
  // Field walk and frozen values
  // ****************************************
  sequence ind_push_s;
    push && st_r == ST_IND;
  endsequence

  // Level alone must skip both two-word fields
  sequence rl_only_s;
    !ind_r[IND_BW_BIT] && !ind_r[IND_FO_BIT] && ind_r[IND_RL_BIT];
  endsequence

  time_order_a: assert property (id_push_s |=> st_r == ST_SEC)
    else $error("seconds word did not follow identifier");
  bw_first_a: assert property ((ind_push_s ##0 ind_r[IND_BW_BIT])
    |=> st_r == ST_BW_HI)
    else $error("bandwidth field not first");
  rl_only_a: assert property ((ind_push_s ##0 rl_only_s) |=> st_r == ST_RL)
    else $error("absent field was sent");
  rpt_ind_a: assert property ((start && !any_chg) |=> ind_r[31:24] == 8'h25)
    else $error("no-change report indicator wrong");
  fo_chg_a: assert property ((start && chg_fo)
    |=> (ind_r[IND_CHG_BIT] && ind_r[IND_FO_BIT]))
    else $error("offset change not flagged");
  len_range_a: assert property (hdr_push_s |-> (word[15:0] >= 16'h0007
    && word[15:0] <= 16'h000B))
    else $error("length field out of range");
  // A snapshot moving mid-packet would mix two configurations
  snap_hold_a: assert property ((st_r != ST_IDLE)
    |=> ($stable(bw_r) && $stable(fo_r) && $stable(rl_r)))
    else $error("snapshot changed during a packet");
  busy_flag_a: assert property ((st_r != ST_IDLE) |=> busy_o)
    else $error("busy low while building");

endmodule

// [bench/dcp_host.sv]
// Purpose: Receiver model that takes packet words over valid/ready
// Assumes: One clock shared with the builder
// Notes:   Slow mode stalls three cycles in four to fill the buffer

`timescale 1ns/1ps

module dcp_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Packet stream
  input  wire logic [31:0] word_i,
  input  wire logic        valid_i,
  input  wire logic        last_i,
  output logic             ready_o,
  // Pacing
  input  wire logic        slow_i
);
  logic [31:0] words[$];
  logic [31:0] got_q[$];
  int          n_pkts;
  logic [1:0]  ph_r;

  // ****************************************
  // Word capture
  // ****************************************
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ph_r    <= 2'h0;
      ready_o <= 1'b0;
      n_pkts  = 0;
      words.delete();
    end
    else
    begin
      ph_r    <= ph_r + 2'h1;
      ready_o <= !slow_i || (ph_r == 2'h2);
      if (valid_i && ready_o)
      begin
        words.push_back(word_i);
        if (last_i)
        begin
          got_q = words;
          words.delete();
          n_pkts++;
        end
      end
    end
  end
endmodule

// [bench/digitizer_context_packet_builder_tb.sv]
// Purpose: Self-checking bench for the context packet builder
// Assumes: Inputs change on the falling edge
// Notes:   Expected packets are built here from the field layout

`timescale 1ns/1ps

module digitizer_context_packet_builder_tb;
  import dcp_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic [63:0] span_bw_i;
  logic [63:0] freq_offset_i;
  logic [15:0] ref_level_i;
  logic [31:0] utc_sec_i;
  logic [63:0] utc_ps_i;
  logic        report_i;
  logic        slow;
  logic [31:0] word_o;
  logic        valid_o;
  logic        last_o;
  logic        ready_i;
  logic        busy_o;
  logic [3:0]  seq_count_o;
  logic [3:0]  exp_cnt;
  int          mismatches;
  int          n_tests;

  dcp_builder DUT (.clk_i(clk_i), .rst_i(rst_i), .span_bw_i(span_bw_i),
    .freq_offset_i(freq_offset_i), .ref_level_i(ref_level_i), .utc_sec_i(utc_sec_i),
    .utc_ps_i(utc_ps_i), .report_i(report_i), .word_o(word_o), .valid_o(valid_o),
    .last_o(last_o), .ready_i(ready_i), .busy_o(busy_o), .seq_count_o(seq_count_o));
  dcp_host u_host (.clk_i(clk_i), .rst_i(rst_i), .word_i(word_o), .valid_i(valid_o),
    .last_i(last_o), .ready_o(ready_i), .slow_i(slow));

  // ****************************************
  // Clock, reset, watchdog
  // ****************************************
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  initial
  begin
    #(40 * 20000);
    mismatches++;
    print_verdict();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for one whole packet and checks every word of it
  task automatic run_pkt(input logic [31:0] ind);
    logic [15:0] len;
    int          k;
    int          n0;
    len = FIXED_WORDS + (ind[29] ? BW_WORDS : 16'h0) + (ind[26] ? FO_WORDS : 16'h0)
        + (ind[24] ? RL_WORDS : 16'h0);
    @(negedge clk_i);
    check({31'h0, busy_o}, 32'h1);
    n0 = u_host.n_pkts;
    k = 0;
    while (u_host.n_pkts == n0 && k < 400)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    check(u_host.n_pkts - n0, 32'h1);
    check(u_host.got_q.size(), {16'h0, len});
    check(u_host.got_q[0], {4'h4, 1'b0, 2'h0, 1'b0, 2'h1, 2'h2, exp_cnt, len});
    check(u_host.got_q[1], 32'h0900_0002);
    check(u_host.got_q[2], utc_sec_i);
    check(u_host.got_q[3], utc_ps_i[63:32]);
    check(u_host.got_q[4], utc_ps_i[31:0]);
    check(u_host.got_q[5], ind);
    k = 6;
    if (ind[29])
    begin
      check(u_host.got_q[k], span_bw_i[63:32]);
      check(u_host.got_q[k+1], span_bw_i[31:0]);
      k += 2;
    end
    if (ind[26])
    begin
      check(u_host.got_q[k], freq_offset_i[63:32]);
      check(u_host.got_q[k+1], freq_offset_i[31:0]);
      k += 2;
    end
    if (ind[24])
      check(u_host.got_q[k], {16'h0000, ref_level_i});
    exp_cnt = exp_cnt + 4'h1;
    @(negedge clk_i);
    check({28'h0, seq_count_o}, {28'h0, exp_cnt});
    check({31'h0, busy_o}, 32'h0);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_i = 1'b1;
    span_bw_i = 64'h0;
    freq_offset_i = 64'h0;
    ref_level_i = 16'h0;
    utc_sec_i = 32'h5F00_0001;
    utc_ps_i = 64'h0000_00E8_D4A5_0FFF;
    report_i = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    n_tests = 0;
    exp_cnt = 4'h0;
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    check({31'h0, valid_o}, 32'h0);
    check({28'h0, seq_count_o}, 32'h0);
    $display("test reset done");
    span_bw_i = 64'h0000_0009_8968_0000;
    run_pkt(32'hA000_0000);
    $display("test bandwidth done");
    slow = 1'b1;
    utc_sec_i = 32'h5F00_0002;
    freq_offset_i = 64'hFFFF_FFFF_FFF0_0000;
    ref_level_i = 16'hFF80;
    run_pkt(32'h8500_0000);
    $display("test offset and level done");
    report_i = 1'b1;
    @(negedge clk_i);
    report_i = 1'b0;
    run_pkt(32'h2500_0000);
    $display("test report done");
    repeat (30) @(negedge clk_i);
    check(u_host.n_pkts, 32'h3);
    $display("test idle done");
    for (int i = 0; i < 16; i++)
    begin
      slow = i[0];
      utc_ps_i = utc_ps_i + 64'h1;
      ref_level_i = ref_level_i + 16'h0001;
      run_pkt(32'h8100_0000);
    end
    $display("test counter wrap done");
    print_verdict();
  end
endmodule
